// ---- hdl/display_fan_command_decoder.sv ----
// Overview of operation
// - type 5 with bytes 8,18,99 restarts the device as at power-on
// - type 5 with bytes 12,28,97 pulses the host reset line
// - type 5 with bytes 3,11,95 pulses the host power-off line
// - each accepted type 5 request gets answer type 0x45, no data
// - clear fills all character cells with space, cursor to 0,0
// - top line takes 16 bytes centred, two blanks each side
// - bottom line takes 16 bytes centred, two blanks each side
// - glyph gets eight rows 0..63, first row top, msb leftmost
// - bit 7 set in a glyph row makes that whole row blink
// - cursor command gives column 0..19 and row 0..1
// - bits 3..0 of the first fan-report byte pick the fans reported every 500 ms
// - reports for different fans are staggered by 1/8 second
// - a reported fan runs at full power during its 1/8 slot
// - fan power takes four levels 0..100, fan 1 first
// - at power-up the single-wire bus is enumerated into a table
// - a device restart enumerates the single-wire bus again
// - table query takes index 0..31, answers index plus 8 id bytes
// - first identifier byte is the family code
// - answers echo low six type bits; top bits mark error or not
// - every command is answered well within 250 ms
module display_fan_command_decoder #(
   parameter int EIGHTH_CYCLES     = display_fan_pkg::EIGHTH_CYCLES,
   parameter int HOST_PULSE_CYCLES = display_fan_pkg::HOST_PULSE_CYCLES
) (
   input  wire logic                         clk_in,
   input  wire logic                         reset_in,
   input  wire logic                         cmd_valid_in,
   input  wire display_fan_pkg::cmd_s        cmd_in,
   output logic                              cmd_ready_out,
   input  wire logic                         rsp_ready_in,
   output logic                              rsp_valid_out,
   output display_fan_pkg::rsp_s             rsp_out,
   input  wire display_fan_pkg::fan_meas_t   fan_meas_in,
   output display_fan_pkg::fan_levels_t      fan_power_out,
   output logic                              disp_we_out,
   output display_fan_pkg::disp_wr_s         disp_wr_out,
   output logic                              glyph_we_out,
   output display_fan_pkg::glyph_wr_s        glyph_wr_out,
   output logic [4:0]                        cursor_col_out,
   output logic                              cursor_row_out,
   output logic                              host_reset_out,
   output logic                              host_power_off_out,
   output logic                              device_restart_out,
   output logic                              bus_enum_start_out,
   input  wire logic                         bus_id_we_in,
   input  wire logic [4:0]                   bus_id_idx_in,
   input  wire display_fan_pkg::bus_id_t     bus_id_in
);

   typedef struct packed {
      display_fan_pkg::dec_state_e  st;
      display_fan_pkg::cmd_s        cmd;
      logic [5:0]                   cnt;
      display_fan_pkg::rsp_s        ack;
      display_fan_pkg::rsp_s        rsp;
      logic                         rsp_valid;
      logic                         ready;
      logic                         disp_we;
      display_fan_pkg::disp_wr_s    disp;
      logic                         glyph_we;
      display_fan_pkg::glyph_wr_s   glyph;
      logic [4:0]                   cur_col;
      logic                         cur_row;
      display_fan_pkg::fan_levels_t power;
      display_fan_pkg::fan_levels_t drive;
      logic [3:0]                   rpt_mask;
      logic [1:0]                   slot;
      logic                         rpt_pend;
      logic [1:0]                   rpt_fan;
      logic                         host_rst;
      logic                         host_off;
      logic [15:0]                  pulse_cnt;
      logic                         restart_pend;
      logic                         restart;
      logic                         enum_start;
      logic                         boot;
   } dec_s;

   dec_s                     s_ff;
   dec_s                     nxt_s;
   logic                     tick;
   logic                     free;
   logic [4:0]               col;
   display_fan_pkg::bus_id_t tbl_id;

   // checks length and every parameter range of a command
   function automatic logic cmd_ok(input display_fan_pkg::cmd_s c);
      logic ok;
      ok = 1'b0;
      case (c.kind)
         display_fan_pkg::CMD_RESTART: begin
            ok = (c.len == display_fan_pkg::LEN_RESTART) &&
                 ({c.data[0], c.data[1], c.data[2]} ==
                     display_fan_pkg::SEQ_REBOOT ||
                  {c.data[0], c.data[1], c.data[2]} ==
                     display_fan_pkg::SEQ_HOST_RST ||
                  {c.data[0], c.data[1], c.data[2]} ==
                     display_fan_pkg::SEQ_HOST_OFF);
         end
         display_fan_pkg::CMD_CLEAR: begin
            ok = (c.len == display_fan_pkg::LEN_NONE);
         end
         display_fan_pkg::CMD_LINE_TOP,
         display_fan_pkg::CMD_LINE_BOT: begin
            ok = (c.len == display_fan_pkg::LEN_LINE);
         end
         display_fan_pkg::CMD_GLYPH: begin
            ok = (c.len == display_fan_pkg::LEN_GLYPH) &&
                 (c.data[0] <= display_fan_pkg::MAX_GLYPH);
            for (int i = 1; i < 9; i++) begin
               if (c.data[i][display_fan_pkg::SPARE_BIT]) begin
                  ok = 1'b0;
               end
            end
         end
         display_fan_pkg::CMD_CURSOR: begin
            ok = (c.len == display_fan_pkg::LEN_CURSOR) &&
                 (c.data[0] <= display_fan_pkg::MAX_COL) &&
                 (c.data[1] <= display_fan_pkg::MAX_ROW);
         end
         display_fan_pkg::CMD_FAN_RPT: begin
            ok = (c.len == display_fan_pkg::LEN_FAN_RPT);
         end
         display_fan_pkg::CMD_FAN_PWR: begin
            ok = (c.len == display_fan_pkg::LEN_FAN_PWR);
            for (int i = 0; i < display_fan_pkg::FANS; i++) begin
               if (c.data[i] > display_fan_pkg::MAX_POWER) begin
                  ok = 1'b0;
               end
            end
         end
         display_fan_pkg::CMD_TABLE_RD: begin
            ok = (c.len == display_fan_pkg::LEN_TABLE) &&
                 (c.data[0] <= display_fan_pkg::MAX_INDEX);
         end
         default: begin
            ok = 1'b0;
         end
      endcase
      return ok;
   endfunction

   // empty answer with the command's low six type bits
   function automatic display_fan_pkg::rsp_s mk_ack(input logic [7:0] k,
                                                    input logic       ok);
      display_fan_pkg::rsp_s r;
      r = '0;
      r.kind = (ok ? display_fan_pkg::RSP_FLAG : display_fan_pkg::ERR_FLAG)
               | {2'b00, k[5:0]};
      r.len = display_fan_pkg::RLEN_NONE;
      return r;
   endfunction

   // linear character cell address from row and column
   function automatic logic [5:0] cell_addr(input logic       row,
                                            input logic [4:0] c);
      return row ? 6'(c) + display_fan_pkg::ROW_BASE1 : 6'(c);
   endfunction

   eighth_tick #(
      .PERIOD   (EIGHTH_CYCLES)
   ) u_tick (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .tick_out (tick)
   );

   bus_device_table u_table (
      .clk_in    (clk_in),
      .wr_en_in  (bus_id_we_in),
      .wr_idx_in (bus_id_idx_in),
      .wr_id_in  (bus_id_in),
      .rd_idx_in (s_ff.cmd.data[0][4:0]),
      .rd_id_out (tbl_id)
   );

   assign free = !s_ff.rsp_valid || rsp_ready_in;
   assign col  = s_ff.cnt[4:0];

   // command sequencing, answers, reports and fan drive
   always_comb begin
      nxt_s = s_ff;
      nxt_s.disp_we = 1'b0;
      nxt_s.glyph_we = 1'b0;
      nxt_s.restart = 1'b0;
      nxt_s.enum_start = s_ff.boot;
      nxt_s.boot = 1'b0;
      if (s_ff.rsp_valid && rsp_ready_in) begin
         nxt_s.rsp_valid = 1'b0;
      end
      // host line pulse length
      if (s_ff.pulse_cnt != '0) begin
         nxt_s.pulse_cnt = s_ff.pulse_cnt - 16'h0001;
      end else begin
         nxt_s.host_rst = 1'b0;
         nxt_s.host_off = 1'b0;
      end
      case (s_ff.st)
         display_fan_pkg::ST_IDLE: begin
            if (cmd_valid_in && s_ff.ready) begin
               nxt_s.cmd = cmd_in;
               nxt_s.cnt = '0;
               nxt_s.ack = mk_ack(cmd_in.kind, cmd_ok(cmd_in));
               nxt_s.st = display_fan_pkg::ST_RESP;
               if (!cmd_ok(cmd_in)) begin
                  nxt_s.st = display_fan_pkg::ST_RESP;
               end else begin
                  case (cmd_in.kind)
                     display_fan_pkg::CMD_RESTART: begin
                        case ({cmd_in.data[0], cmd_in.data[1],
                               cmd_in.data[2]})
                           display_fan_pkg::SEQ_HOST_RST: begin
                              nxt_s.host_rst = 1'b1;
                              nxt_s.pulse_cnt =
                                 16'(HOST_PULSE_CYCLES - 1);
                           end
                           display_fan_pkg::SEQ_HOST_OFF: begin
                              nxt_s.host_off = 1'b1;
                              nxt_s.pulse_cnt =
                                 16'(HOST_PULSE_CYCLES - 1);
                           end
                           default: begin
                              nxt_s.restart_pend = 1'b1;
                           end
                        endcase
                     end
                     display_fan_pkg::CMD_CURSOR: begin
                        nxt_s.cur_col = cmd_in.data[0][4:0];
                        nxt_s.cur_row = cmd_in.data[1][0];
                     end
                     display_fan_pkg::CMD_FAN_RPT: begin
                        nxt_s.rpt_mask = (cmd_in.data[0] != 8'h00) ?
                                         cmd_in.data[0][3:0] : 4'h0;
                     end
                     display_fan_pkg::CMD_FAN_PWR: begin
                        for (int i = 0; i < display_fan_pkg::FANS; i++) begin
                           nxt_s.power[i] = cmd_in.data[i][6:0];
                        end
                     end
                     display_fan_pkg::CMD_TABLE_RD: begin
                        nxt_s.st = display_fan_pkg::ST_TABLE;
                     end
                     default: begin
                        nxt_s.st = display_fan_pkg::ST_WRITE;
                     end
                  endcase
               end
            end
         end
         display_fan_pkg::ST_WRITE: begin
            nxt_s.cnt = s_ff.cnt + 6'h01;
            case (s_ff.cmd.kind)
               display_fan_pkg::CMD_CLEAR: begin
                  nxt_s.disp_we = 1'b1;
                  nxt_s.disp.addr = s_ff.cnt;
                  nxt_s.disp.ch = display_fan_pkg::SPACE;
                  if (s_ff.cnt == display_fan_pkg::LAST_CELL) begin
                     nxt_s.cur_col = '0;
                     nxt_s.cur_row = 1'b0;
                     nxt_s.st = display_fan_pkg::ST_RESP;
                  end
               end
               display_fan_pkg::CMD_GLYPH: begin
                  nxt_s.glyph_we = 1'b1;
                  nxt_s.glyph.idx = s_ff.cmd.data[0][2:0];
                  nxt_s.glyph.row = s_ff.cnt[2:0];
                  nxt_s.glyph.pix = s_ff.cmd.data[4'(s_ff.cnt + 6'h01)][5:0];
                  nxt_s.glyph.blink = s_ff.cmd.data[4'(s_ff.cnt + 6'h01)]
                                      [display_fan_pkg::BLINK_BIT];
                  if (s_ff.cnt == display_fan_pkg::LAST_ROW8) begin
                     nxt_s.st = display_fan_pkg::ST_RESP;
                  end
               end
               default: begin
                  // line writes, centred with blank margins
                  nxt_s.disp_we = 1'b1;
                  nxt_s.disp.addr = cell_addr(
                     s_ff.cmd.kind == display_fan_pkg::CMD_LINE_BOT, col);
                  if (col < display_fan_pkg::LEFT_PAD ||
                      col >= display_fan_pkg::RIGHT_PAD) begin
                     nxt_s.disp.ch = display_fan_pkg::SPACE;
                  end else begin
                     nxt_s.disp.ch =
                        s_ff.cmd.data[4'(col - display_fan_pkg::LEFT_PAD)];
                  end
                  if (s_ff.cnt == display_fan_pkg::LAST_COL) begin
                     nxt_s.st = display_fan_pkg::ST_RESP;
                  end
               end
            endcase
         end
         display_fan_pkg::ST_TABLE: begin
            // one cycle for the registered table read
            nxt_s.cnt = s_ff.cnt + 6'h01;
            if (s_ff.cnt != '0) begin
               nxt_s.ack.len = display_fan_pkg::RLEN_TABLE;
               nxt_s.ack.data[0] = s_ff.cmd.data[0];
               for (int i = 0; i < 8; i++) begin
                  nxt_s.ack.data[i + 1] = tbl_id[i];
               end
               nxt_s.st = display_fan_pkg::ST_RESP;
            end
         end
         display_fan_pkg::ST_RESP: begin
            if (free) begin
               nxt_s.rsp = s_ff.ack;
               nxt_s.rsp_valid = 1'b1;
               nxt_s.st = display_fan_pkg::ST_IDLE;
               if (s_ff.restart_pend) begin
                  // restart in the same cycle its answer is put out
                  nxt_s.restart_pend = 1'b0;
                  nxt_s.restart = 1'b1;
                  nxt_s.enum_start = 1'b1;
                  nxt_s.power = {display_fan_pkg::FANS{display_fan_pkg::RST_PWR}};
                  nxt_s.rpt_mask = '0;
                  nxt_s.rpt_pend = 1'b0;
                  nxt_s.cur_col = '0;
                  nxt_s.cur_row = 1'b0;
               end
            end
         end
         default: begin
            nxt_s.st = display_fan_pkg::ST_IDLE;
         end
      endcase
      // a pending fan report uses the channel when no answer waits
      if (s_ff.st != display_fan_pkg::ST_RESP && free && s_ff.rpt_pend) begin
         nxt_s.rpt_pend = 1'b0;
         nxt_s.rsp_valid = 1'b1;
         nxt_s.rsp = '0;
         nxt_s.rsp.kind = display_fan_pkg::FAN_REPORT;
         nxt_s.rsp.len = display_fan_pkg::RLEN_FAN;
         nxt_s.rsp.data[0] = {6'h00, s_ff.rpt_fan};
         nxt_s.rsp.data[1] = fan_meas_in[s_ff.rpt_fan].tach_cycles;
         nxt_s.rsp.data[2] = fan_meas_in[s_ff.rpt_fan].timer_ticks[15:8];
         nxt_s.rsp.data[3] = fan_meas_in[s_ff.rpt_fan].timer_ticks[7:0];
      end
      // each eighth second moves to the next fan slot
      if (tick) begin
         nxt_s.slot = s_ff.slot + 2'b01;
         if (nxt_s.rpt_mask[nxt_s.slot]) begin
            nxt_s.rpt_pend = 1'b1;
            nxt_s.rpt_fan = nxt_s.slot;
         end
      end
      // reported fan runs flat out during its own slot
      for (int i = 0; i < display_fan_pkg::FANS; i++) begin
         nxt_s.drive[i] = (nxt_s.rpt_mask[i] && nxt_s.slot == 2'(i)) ?
                          display_fan_pkg::FULL_PWR : nxt_s.power[i];
      end
      nxt_s.ready = (nxt_s.st == display_fan_pkg::ST_IDLE);
   end

   // state register; boot flag starts the first enumeration
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_ff <= '0;
         s_ff.boot <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign cmd_ready_out      = s_ff.ready;
   assign rsp_valid_out      = s_ff.rsp_valid;
   assign rsp_out            = s_ff.rsp;
   assign fan_power_out      = s_ff.drive;
   assign disp_we_out        = s_ff.disp_we;
   assign disp_wr_out        = s_ff.disp;
   assign glyph_we_out       = s_ff.glyph_we;
   assign glyph_wr_out       = s_ff.glyph;
   assign cursor_col_out     = s_ff.cur_col;
   assign cursor_row_out     = s_ff.cur_row;
   assign host_reset_out     = s_ff.host_rst;
   assign host_power_off_out = s_ff.host_off;
   assign device_restart_out = s_ff.restart;
   assign bus_enum_start_out = s_ff.enum_start;

endmodule

// ---- hdl/display_fan_pkg.sv ----
package display_fan_pkg;

   // timing
   localparam int CLK_HZ            = 32'h02FA_F080;
   localparam int MS_PER_S          = 32'h0000_03E8;
   localparam int US_PER_S          = 32'h000F_4240;
   localparam int EIGHTH_MS         = 32'h0000_007D;
   localparam int EIGHTH_CYCLES     = CLK_HZ / MS_PER_S * EIGHTH_MS;
   localparam int HOST_PULSE_US     = 32'h0000_0064;
   localparam int HOST_PULSE_CYCLES = CLK_HZ / US_PER_S * HOST_PULSE_US;
   localparam int ANSWER_MS         = 32'h0000_00FA;

   // command codes
   localparam logic [7:0] CMD_RESTART  = 8'h05;
   localparam logic [7:0] CMD_CLEAR    = 8'h06;
   localparam logic [7:0] CMD_LINE_TOP = 8'h07;
   localparam logic [7:0] CMD_LINE_BOT = 8'h08;
   localparam logic [7:0] CMD_GLYPH    = 8'h09;
   localparam logic [7:0] CMD_CURSOR   = 8'h0B;
   localparam logic [7:0] CMD_FAN_RPT  = 8'h10;
   localparam logic [7:0] CMD_FAN_PWR  = 8'h11;
   localparam logic [7:0] CMD_TABLE_RD = 8'h12;

   // answer codes
   localparam logic [7:0] RSP_FLAG   = 8'h40;
   localparam logic [7:0] ERR_FLAG   = 8'hC0;
   localparam logic [7:0] FAN_REPORT = 8'h81;

   // lengths
   localparam logic [4:0] LEN_NONE    = 5'h00;
   localparam logic [4:0] LEN_RESTART = 5'h03;
   localparam logic [4:0] LEN_LINE    = 5'h10;
   localparam logic [4:0] LEN_GLYPH   = 5'h09;
   localparam logic [4:0] LEN_CURSOR  = 5'h02;
   localparam logic [4:0] LEN_FAN_RPT = 5'h01;
   localparam logic [4:0] LEN_FAN_PWR = 5'h04;
   localparam logic [4:0] LEN_TABLE   = 5'h01;
   localparam logic [3:0] RLEN_NONE   = 4'h0;
   localparam logic [3:0] RLEN_FAN    = 4'h4;
   localparam logic [3:0] RLEN_TABLE  = 4'h9;

   // restart sub-codes, first data byte leftmost
   localparam logic [23:0] SEQ_REBOOT   = 24'h08_1263;
   localparam logic [23:0] SEQ_HOST_RST = 24'h0C_1C61;
   localparam logic [23:0] SEQ_HOST_OFF = 24'h03_0B5F;

   // display geometry and limits
   localparam logic [7:0] SPACE     = 8'h20;
   localparam logic [5:0] ROW_BASE1 = 6'h14;
   localparam logic [5:0] LAST_CELL = 6'h27;
   localparam logic [5:0] LAST_COL  = 6'h13;
   localparam logic [5:0] LAST_ROW8 = 6'h07;
   localparam logic [4:0] LEFT_PAD  = 5'h02;
   localparam logic [4:0] RIGHT_PAD = 5'h12;
   localparam logic [7:0] MAX_COL   = 8'h13;
   localparam logic [7:0] MAX_ROW   = 8'h01;
   localparam logic [7:0] MAX_GLYPH = 8'h07;
   localparam logic [7:0] MAX_INDEX = 8'h1F;
   localparam logic [7:0] MAX_POWER = 8'h64;
   localparam logic [6:0] FULL_PWR  = 7'h64;
   localparam logic [6:0] RST_PWR   = 7'h00;
   localparam int         BLINK_BIT = 32'h0000_0007;
   localparam int         SPARE_BIT = 32'h0000_0006;
   localparam int         FANS      = 32'h0000_0004;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WRITE = 2'b01,
      ST_RESP  = 2'b11,
      ST_TABLE = 2'b10
   } dec_state_e;

   typedef struct packed {
      logic [7:0]       kind;
      logic [4:0]       len;
      logic [15:0][7:0] data;
   } cmd_s;

   typedef struct packed {
      logic [7:0]      kind;
      logic [3:0]      len;
      logic [8:0][7:0] data;
   } rsp_s;

   typedef struct packed {
      logic [7:0]  tach_cycles;
      logic [15:0] timer_ticks;
   } fan_meas_s;

   typedef fan_meas_s [3:0] fan_meas_t;
   typedef logic [3:0][6:0] fan_levels_t;
   typedef logic [7:0][7:0] bus_id_t;

   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] ch;
   } disp_wr_s;

   typedef struct packed {
      logic [2:0] idx;
      logic [2:0] row;
      logic [5:0] pix;
      logic       blink;
   } glyph_wr_s;

endpackage

// ---- hdl/eighth_tick.sv ----
module eighth_tick #(
   parameter int PERIOD = display_fan_pkg::EIGHTH_CYCLES
) (
   input  wire logic clk_in,
   input  wire logic reset_in,
   output logic      tick_out
);

   typedef struct packed {
      logic [22:0] cnt;
      logic        tick;
   } tick_s;

   tick_s s_ff;
   tick_s nxt_s;

   // free running period counter, one pulse per wrap
   always_comb begin
      nxt_s = s_ff;
      nxt_s.tick = 1'b0;
      if (s_ff.cnt == 23'(PERIOD - 1)) begin
         nxt_s.cnt = '0;
         nxt_s.tick = 1'b1;
      end else begin
         nxt_s.cnt = s_ff.cnt + 23'h00_0001;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign tick_out = s_ff.tick;

endmodule

// ---- hdl/bus_device_table.sv ----
module bus_device_table (
   input  wire logic                      clk_in,
   input  wire logic                      wr_en_in,
   input  wire logic [4:0]                wr_idx_in,
   input  wire display_fan_pkg::bus_id_t  wr_id_in,
   input  wire logic [4:0]                rd_idx_in,
   output display_fan_pkg::bus_id_t       rd_id_out
);

   display_fan_pkg::bus_id_t mem [32];
   display_fan_pkg::bus_id_t rd_ff;

   // identifier store with registered read
   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_idx_in] <= wr_id_in;
      end
      rd_ff <= mem[rd_idx_in];
   end

   assign rd_id_out = rd_ff;

endmodule

// ---- verif/host_model.sv ----
module host_model (
   input  wire logic                  clk_in,
   input  wire logic                  reset_in,
   input  wire logic                  slow_in,
   input  wire logic                  rsp_valid_in,
   input  wire display_fan_pkg::rsp_s rsp_in,
   output logic                       rsp_ready_out,
   output display_fan_pkg::rsp_s      got_out,
   output int                         count_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // takes answers at once, or stalls on every other cycle
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         rsp_ready_out <= 1'b0;
         count_out <= 0;
      end else begin
         rsp_ready_out <= !slow_in || !rsp_ready_out;
         if (rsp_valid_in && rsp_ready_out) begin
            got_out <= rsp_in;
            count_out <= count_out + 1;
         end
      end
   end
endmodule

// ---- verif/dfcd_asserts.sv ----
module dfcd_asserts (
   input wire logic                  clk_in,
   input wire logic                  reset_in,
   input wire logic                  cmd_valid_in,
   input wire display_fan_pkg::cmd_s cmd_in,
   input wire logic                  cmd_ready_out,
   input wire logic                  rsp_ready_in,
   input wire logic                  rsp_valid_out,
   input wire display_fan_pkg::rsp_s rsp_out,
   input wire logic                  disp_we_out,
   input wire display_fan_pkg::disp_wr_s disp_wr_out,
   input wire logic [4:0]            cursor_col_out,
   input wire logic                  cursor_row_out,
   input wire logic                  host_reset_out,
   input wire logic                  host_power_off_out,
   input wire logic                  device_restart_out,
   input wire logic                  bus_enum_start_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   logic [7:0] kind_ff;
   wire        take = cmd_valid_in && cmd_ready_out;
   // remembers the kind of the command in flight
   always_ff @(posedge clk_in) if (take) kind_ff <= cmd_in.kind;
   rsp_hold_a: assert property (rsp_valid_out && !rsp_ready_in
      |=> rsp_valid_out && $stable(rsp_out)) else $error("rsp dropped");
   err_len_a: assert property (
      rsp_valid_out && rsp_out.kind[7:6] == 2'b11
      |-> rsp_out.len == 4'h0) else $error("error has data");
   echo_kind_a: assert property (
      rsp_valid_out && rsp_out.kind != 8'h81 |->
      rsp_out.kind[5:0] == kind_ff[5:0]) else $error("bad echo");
   ready_drop_a: assert property (take |=> !cmd_ready_out)
      else $error("ready stays up");
   host_pulse_a: assert property ($rose(host_reset_out) |->
      host_reset_out[*4] ##1 !host_reset_out) else $error("reset length");
   off_pulse_a: assert property ($rose(host_power_off_out) |->
      host_power_off_out[*4] ##1 !host_power_off_out) else $error("off len");
   restart_enum_a: assert property (device_restart_out |->
      bus_enum_start_out ##1 !device_restart_out) else $error("no enum");
   cursor_set_a: assert property (take && cmd_in.kind == 8'h0B &&
      cmd_in.len == 5'h02 && cmd_in.data[0] < 8'h14 && cmd_in.data[1] < 8'h02
      |=> cursor_col_out == $past(cmd_in.data[0][4:0])) else $error("cursor");
   line_blank_a: assert property (
      disp_we_out && (disp_wr_out.addr % 20 < 2 ||
      disp_wr_out.addr % 20 > 17) |-> disp_wr_out.ch == 8'h20)
      else $error("edge not blank");
   // main scenarios
   cover property ($rose(host_reset_out));
   cover property (rsp_valid_out && rsp_out.kind == 8'h81);
   cover property (rsp_valid_out && rsp_out.kind == 8'hCB);
endmodule

// ---- verif/tb_display_fan_command_decoder.sv ----
module tb_display_fan_command_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0, reset_in = 1, cmd_valid_in = 0, bus_id_we_in = 0;
   logic slow = 0, rsp_ready_in, cmd_ready_out, rsp_valid_out, disp_we_out;
   logic glyph_we_out, cursor_row_out, host_reset_out, host_power_off_out;
   logic device_restart_out, bus_enum_start_out;
   logic [4:0] bus_id_idx_in = 5'h05, cursor_col_out;
   display_fan_pkg::cmd_s       cmd_in = '0;
   display_fan_pkg::rsp_s       rsp_out, got;
   display_fan_pkg::fan_meas_t  fan_meas_in = 96'h0007_1234;
   display_fan_pkg::fan_levels_t fan_power_out;
   display_fan_pkg::disp_wr_s   disp_wr_out;
   display_fan_pkg::glyph_wr_s  glyph_wr_out;
   display_fan_pkg::bus_id_t    bus_id_in = 64'h1122_3344_5566_7710;
   int fail_count = 0, tests_run = 0, count, cyc = 0;
   display_fan_pkg::glyph_wr_s  glast;
   logic [7:0]                  cell2;
   // last glyph row 1 write and last write to top row column 2
   always @(posedge clk_in) begin
      if (glyph_we_out && glyph_wr_out.row == 3'h1) glast <= glyph_wr_out;
      if (disp_we_out && disp_wr_out.addr == 6'h02) cell2 <= disp_wr_out.ch;
   end
   display_fan_command_decoder #(.EIGHTH_CYCLES(16), .HOST_PULSE_CYCLES(4))
      display_fan_command_decoder_inst (.*);
   host_model host_model_inst (.clk_in(clk_in), .reset_in(reset_in),
      .slow_in(slow), .rsp_valid_in(rsp_valid_out), .rsp_in(rsp_out),
      .rsp_ready_out(rsp_ready_in), .got_out(got), .count_out(count));
   // clock and hang guard
   always #10 clk_in = ~clk_in;
   always @(posedge clk_in) if (++cyc == 5000) begin
      fail_count++;
      finish_test;
   end
   task automatic finish_test;
      if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(string s, logic [71:0] e, logic [71:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic wait_rsp;
      int n;
      n = count;
      while (count == n) @(posedge clk_in);
   endtask
   task automatic run(logic [7:0] k, logic [4:0] l, logic [127:0] d,
                      logic [7:0] ek);
      cmd_in <= {k, l, d};
      cmd_valid_in <= 1'b1;
      @(posedge clk_in);
      while (cmd_ready_out !== 1'b1) @(posedge clk_in);
      cmd_valid_in <= 1'b0;
      wait_rsp();
      chk("kind", ek, got.kind);
   endtask
   // command sequence
   initial begin
      repeat (5) @(posedge clk_in);
      reset_in <= 1'b0;
      @(posedge clk_in);
      bus_id_we_in <= 1'b1;
      @(posedge clk_in);
      bus_id_we_in <= 1'b0;
      run(8'h12, 5'h01, 128'h05, 8'h52);
      chk("table", {bus_id_in, 8'h05}, got.data);
      run(8'h12, 5'h01, 128'h20, 8'hD2);
      run(8'h0B, 5'h02, 128'h0113, 8'h4B);
      run(8'h0B, 5'h02, 128'h0014, 8'hCB);
      chk("col", 72'h13, cursor_col_out);
      run(8'h11, 5'h04, 128'h0132_0064, 8'h51);
      run(8'h11, 5'h04, 128'h0065_0000, 8'hD1);
      chk("pwr", {7'd1, 7'd50, 7'd0, 7'd100}, fan_power_out);
      run(8'h09, 5'h09, 128'h0102_0408_1020_803F_02, 8'h49);
      chk("glyph", {3'h2, 3'h1, 6'h00, 1'b1}, glast);
      run(8'h09, 5'h09, 128'h40_02, 8'hC9);
      run(8'h07, 5'h10, "PONMLKJIHGFEDCBA", 8'h47);
      chk("cell", 72'h41, cell2);
      run(8'h08, 5'h10, "abcdefghijklmnop", 8'h48);
      run(8'h06, 5'h00, 128'h0, 8'h46);
      chk("home", 72'h0, {cursor_col_out, cursor_row_out});
      run(8'h0A, 5'h00, 128'h0, 8'hCA);
      slow <= 1'b1;
      run(8'h05, 5'h03, 128'h61_1C0C, 8'h45);
      run(8'h05, 5'h03, 128'h5F_0B03, 8'h45);
      run(8'h05, 5'h03, 128'h63_1208, 8'h45);
      chk("reboot", 72'h0, fan_power_out);
      slow <= 1'b0;
      run(8'h10, 5'h01, 128'h01, 8'h50);
      wait_rsp();
      chk("report", 72'h81_3412_0700, {got.kind, got.data[3:0]});
      chk("full", 72'h64, fan_power_out[0]);
      finish_test;
   end
endmodule
bind display_fan_command_decoder dfcd_asserts dfcd_asserts_inst (.*);
